//--- hw/ptc_bank.sv
// Upper terminal connect register for resistor networks 3 and 2, with switch drive.
`timescale 1ns/1ps
`default_nettype none
module ptc_bank
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic wr_valid,
    input wire logic [ptc_pkg::PTC_REG_W-1:0] wr_data,
    input wire logic shutdown_pin_n,
    output ptc_pkg::ptc_tcon_t rd_data,
    output ptc_pkg::ptc_net_sw_t net3_sw,
    output ptc_pkg::ptc_net_sw_t net2_sw,
    output logic net3_in_shutdown,
    output logic net2_in_shutdown
);
    import ptc_pkg::*;

    // ==================================================================
    // Shutdown pin synchronisation.
    logic pin_shdn_n_s;

    ptc_sync2 u_shdn_sync
    (
        .clock(clock),
        .nrst(nrst),
        .async_in(shutdown_pin_n),
        .sync_out(pin_shdn_n_s)
    );

    // ==================================================================
    // Register storage.
    ptc_tcon_t tcon;
    ptc_tcon_t next_tcon;
    ptc_tcon_t wr_view;

    assign wr_view = ptc_tcon_t'(wr_data);

    always_comb
    begin
        next_tcon = tcon;
        if (wr_valid)
        begin
            next_tcon = wr_view;
        end
        // The top bit holds its fixed value whatever is written.
        next_tcon.reserved_high_one = PTC_RSVD_VALUE;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            tcon <= ptc_tcon_t'(PTC_REG_RESET);
        else
            tcon <= next_tcon;
    end

    assign rd_data = tcon;

    // ==================================================================
    // Switch drive.
    // A network is in shutdown when its hardware bit is zero or the pin is low.
    // In shutdown terminal A opens and the wiper is tied to terminal B;
    // the register bits themselves are left untouched.
    ptc_net_sw_t sw3;
    ptc_net_sw_t sw2;
    ptc_net_sw_t next_sw3;
    ptc_net_sw_t next_sw2;
    logic sd3;
    logic sd2;
    logic next_sd3;
    logic next_sd2;

    always_comb
    begin
        next_sd3 = !tcon.net3_hw_shutdown_override || !pin_shdn_n_s;
        next_sd2 = !tcon.net2_hw_shutdown_override || !pin_shdn_n_s;
        next_sw3.term_a = tcon.net3_term_a_connect && !next_sd3;
        next_sw3.wiper = tcon.net3_wiper_connect;
        next_sw3.term_b = tcon.net3_term_b_connect;
        next_sw3.wiper_to_b = next_sd3;
        next_sw2.term_a = tcon.net2_term_a_connect && !next_sd2;
        next_sw2.wiper = tcon.net2_wiper_connect;
        next_sw2.term_b = tcon.net2_term_b_connect;
        next_sw2.wiper_to_b = next_sd2;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sw3 <= ptc_net_sw_t'(PTC_SW_RESET);
            sw2 <= ptc_net_sw_t'(PTC_SW_RESET);
            sd3 <= PTC_SD_RESET;
            sd2 <= PTC_SD_RESET;
        end
        else
        begin
            sw3 <= next_sw3;
            sw2 <= next_sw2;
            sd3 <= next_sd3;
            sd2 <= next_sd2;
        end
    end

    assign net3_sw = sw3;
    assign net2_sw = sw2;
    assign net3_in_shutdown = sd3;
    assign net2_in_shutdown = sd2;

    // ==================================================================
    // Checks.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_rsvd_reads_one: assert property (rd_data.reserved_high_one == 1'h1)
        else $error("reserved bit not one");

    a_rsvd_write_zero: assert property (wr_valid && !wr_data[PTC_BIT_RSVD]
        |=> rd_data.reserved_high_one)
        else $error("reserved bit took a written zero");

    a_n3a_follows: assert property (wr_valid && pin_shdn_n_s
        && wr_data[PTC_BIT_N3_HW] ##1 pin_shdn_n_s
        |=> net3_sw.term_a == $past(wr_data[PTC_BIT_N3_A], 2))
        else $error("net3 terminal A switch wrong");

    a_n3w_follows: assert property (wr_valid
        |=> ##1 net3_sw.wiper == $past(wr_data[PTC_BIT_N3_W], 2))
        else $error("net3 wiper switch wrong");

    a_n3b_follows: assert property (wr_valid
        |=> ##1 net3_sw.term_b == $past(wr_data[PTC_BIT_N3_B], 2))
        else $error("net3 terminal B switch wrong");

    a_n3b_field: assert property (wr_valid
        |=> rd_data.net3_term_b_connect == $past(wr_data[PTC_BIT_N3_B]))
        else $error("net3 terminal B field wrong");

    a_hw_force_sd: assert property (!rd_data.net3_hw_shutdown_override
        |=> net3_in_shutdown && !net3_sw.term_a && net3_sw.wiper_to_b)
        else $error("net3 not forced into shutdown");

    a_hw_free: assert property (rd_data.net2_hw_shutdown_override
        && pin_shdn_n_s
        |=> !net2_in_shutdown && net2_sw.term_a == $past(rd_data.net2_term_a_connect))
        else $error("net2 shutdown state wrong");

    a_n2w_follows: assert property (wr_valid
        |=> ##1 net2_sw.wiper == $past(wr_data[PTC_BIT_N2_W], 2))
        else $error("net2 wiper switch wrong");

    a_hold_no_write: assert property (!wr_valid |=> $stable(rd_data))
        else $error("register changed without a write");

    a_reset_ones: assert property ($rose(nrst) |-> rd_data == PTC_REG_RESET)
        else $error("register not all ones after reset");

    c_write_zero: cover property (wr_valid && wr_data == 9'h000);
    c_pin_shutdown: cover property ($fell(pin_shdn_n_s) ##2 net3_in_shutdown);
    c_hw_release: cover property (net2_in_shutdown ##1 !net2_in_shutdown);
    c_back_to_back: cover property (wr_valid [*2]);

endmodule
`default_nettype wire

//--- hw/ptc_pkg.sv
// Package with field layout, reset values and carrier types of the upper terminal register.
package ptc_pkg;

    // ==================================================================
    // Register layout.
    localparam int PTC_REG_W = 9;
    localparam int PTC_BIT_RSVD = 8;
    localparam int PTC_BIT_N3_HW = 7;
    localparam int PTC_BIT_N3_A = 6;
    localparam int PTC_BIT_N3_W = 5;
    localparam int PTC_BIT_N3_B = 4;
    localparam int PTC_BIT_N2_HW = 3;
    localparam int PTC_BIT_N2_A = 2;
    localparam int PTC_BIT_N2_W = 1;
    localparam int PTC_BIT_N2_B = 0;
    localparam logic [8:0] PTC_REG_RESET = 9'h1FF;
    localparam logic PTC_RSVD_VALUE = 1'h1;
    localparam logic [3:0] PTC_SW_RESET = 4'hE;
    localparam logic PTC_SD_RESET = 1'h0;
    localparam int PTC_SYNC_STAGES = 2;

    // ==================================================================
    // Register view, most significant field first.
    typedef struct packed {
        logic reserved_high_one;
        logic net3_hw_shutdown_override;
        logic net3_term_a_connect;
        logic net3_wiper_connect;
        logic net3_term_b_connect;
        logic net2_hw_shutdown_override;
        logic net2_term_a_connect;
        logic net2_wiper_connect;
        logic net2_term_b_connect;
    } ptc_tcon_t;

    // Switch drive for one resistor network.
    typedef struct packed {
        logic term_a;
        logic wiper;
        logic term_b;
        logic wiper_to_b;
    } ptc_net_sw_t;

endpackage

//--- hw/ptc_sync2.sv
// Two-stage synchroniser for one asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module ptc_sync2
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);
    import ptc_pkg::*;

    // ==================================================================
    // Synchroniser chain, reset to the inactive (high) level.
    logic [PTC_SYNC_STAGES-1:0] stages;
    logic [PTC_SYNC_STAGES-1:0] next_stages;

    always_comb
    begin
        next_stages = {stages[PTC_SYNC_STAGES-2:0], async_in};
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            stages <= '1;
        else
            stages <= next_stages;
    end

    assign sync_out = stages[PTC_SYNC_STAGES-1];
endmodule
`default_nettype wire

//--- verif/ptc_host_model.sv
// Host model that writes the upper terminal connect register.
`timescale 1ns/1ps
`default_nettype none
module ptc_host_model
(
    input wire logic clock,
    output logic wr_valid,
    output logic [8:0] wr_data
);
    // ==================================================================
    // Write tasks, entered just after a clock edge.
    initial
    begin
        wr_valid = 1'h0;
        wr_data = 9'h000;
    end
    // Presents one word and returns at the edge that takes it.
    task automatic put(input logic [8:0] v);
        wr_valid <= 1'h1;
        wr_data <= v;
        @(posedge clock);
    endtask
    // Releases the port; data is inverted so stale bits are never reused.
    task automatic idle(input int n);
        wr_valid <= 1'h0;
        wr_data <= ~wr_data;
        repeat (n) @(posedge clock);
    endtask
endmodule
`default_nettype wire

//--- verif/tb_ptc_bank.sv
// Testbench for the upper terminal connect register.
`timescale 1ns/1ps
`default_nettype none
module tb_ptc_bank;
    import ptc_pkg::*;
    logic clock, nrst, shutdown_pin_n, wr_valid, n3_sd, n2_sd;
    logic [8:0] wr_data;
    ptc_tcon_t rd_data;
    ptc_net_sw_t net3_sw, net2_sw;
    int fail_count = 0, checks = 0, cycles = 0;
    ptc_host_model i_ptc_host_model (.clock(clock), .wr_valid(wr_valid), .wr_data(wr_data));
    ptc_bank i_ptc_bank (.clock(clock), .nrst(nrst), .wr_valid(wr_valid), .wr_data(wr_data),
        .shutdown_pin_n(shutdown_pin_n), .rd_data(rd_data), .net3_sw(net3_sw),
        .net2_sw(net2_sw), .net3_in_shutdown(n3_sd), .net2_in_shutdown(n2_sd));
    // ==================================================================
    // Checking helpers.
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [9:0] ex(input logic [8:0] r, input logic p);
        logic s3, s2;
        s3 = !r[7] || !p;
        s2 = !r[3] || !p;
        return {s3, r[6] & !s3, r[5], r[4], s3, s2, r[2] & !s2, r[1], r[0], s2};
    endfunction
    task automatic look(input logic [8:0] v);
        logic [9:0] seen;
        seen = {n3_sd, net3_sw, n2_sd, net2_sw};
        chk("rd_data", {1'h0, v | 9'h100}, {1'h0, rd_data});
        chk("switches", ex(v | 9'h100, shutdown_pin_n), seen);
    endtask
    task automatic wr_look(input logic [8:0] v);
        i_ptc_host_model.put(v);
        i_ptc_host_model.idle(1);
        #1;
        look(v);
        @(posedge clock);
    endtask
    // ==================================================================
    // Scenarios.
    task automatic t_bits;
        wr_look(9'h000);
        for (int i = 0; i < 8; i++)
        begin
            wr_look(~(9'h001 << i) & 9'h0FF);
            wr_look(9'h001 << i);
        end
        i_ptc_host_model.put(9'h0AA);
        wr_look(9'h055);
    endtask
    task automatic t_pin;
        wr_look(9'h1FF);
        shutdown_pin_n <= 1'h0;
        repeat (2) @(posedge clock);
        #1;
        chk("n3_sd early", 10'h000, {9'h000, n3_sd});
        @(posedge clock);
        #1;
        look(9'h1FF);
        @(posedge clock);
        shutdown_pin_n <= 1'h1;
        repeat (4) @(posedge clock);
        wr_look(9'h077);
        nrst <= 1'h0;
        @(posedge clock);
        #1;
        look(9'h1FF);
        @(posedge clock);
        nrst <= 1'h1;
        @(posedge clock);
        #1;
        look(9'h1FF);
        @(posedge clock);
        wr_look(9'h0F0);
    endtask
    task automatic finish_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==================================================================
    // Clock, timeout and main sequence.
    initial
    begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            fail_count++;
            finish_test();
        end
    end
    initial
    begin
        nrst = 1'h0;
        shutdown_pin_n = 1'h1;
        repeat (10) @(posedge clock);
        nrst <= 1'h1;
        @(posedge clock);
        #1;
        look(9'h1FF);
        @(posedge clock);
        t_bits();
        t_pin();
        finish_test();
    end
endmodule
`default_nettype wire
